// >>> design/dor_resolver.sv
`timescale 1ns/1ps

module dor_resolver (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             req_valid,
    input  wire dor_pkg::dor_cmd_e  req_cmd,
    input  wire dor_pkg::dor_type_e req_type,
    input  wire dor_pkg::dor_cop_e  req_cop,
    input  wire logic             req_dbl_marker,
    input  wire logic             req_coil_set,
    input  wire logic [15:0]      req_num,
    input  wire logic [3:0]       req_nib,
    input  wire logic [7:0]       req_elem,
    input  wire logic             req_idx_en,
    input  wire logic             req_idx_long,
    input  wire logic [2:0]       req_idx_sel,
    input  wire logic [31:0]      req_wdata,
    output logic                  req_ready,
    output logic                  ack,
    output logic                  op_err,
    output logic [31:0]           rd_data,
    output logic                  contact_acc,
    output logic                  exec_en,
    output logic [1:0]            bit_space,
    output logic [15:0]           bit_addr,
    output logic                  bit_we,
    output logic [31:0]           bit_wmask,
    output logic [31:0]           bit_wdata,
    input  wire logic [31:0]      bit_rdata,
    output logic [15:0]           word_addr,
    output logic                  word_we,
    output logic [15:0]           word_wdata,
    input  wire logic [15:0]      word_rdata
);
    import dor_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_LO   = 3'b010,
        S_HI   = 3'b100
    } dor_st_e;

    typedef struct packed {
        dor_st_e          st;
        logic             rdy;
        logic             ack;
        logic             err;
        logic [31:0]      rdat;
        logic             acc;
        logic             exec;
        logic [1:0]       space;
        logic [15:0]      addr;
        logic             bwe;
        logic [31:0]      bmask;
        logic [31:0]      bdat;
        logic             wwe;
        logic [15:0]      wdat;
        logic [15:0]      whi;
        logic             dbl;
        logic             wpath;
        logic             grp;
        logic [3:0]       nib;
        dor_cmd_e         cmd;
        dor_cop_e         cop;
        logic [7:0][15:0] v;
        logic [7:0][31:0] z;
    } dor_q_s;

    dor_q_s q;
    dor_q_s n;
    logic   rs1_r;
    logic   rst_s_n;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_r   <= 1'b0;
            rst_s_n <= 1'b0;
        end else begin
            rs1_r   <= 1'b1;
            rst_s_n <= rs1_r;
        end
    end

    // ************************************************************
    // Operand address resolution
    // ************************************************************
    logic        acc_req;
    logic        is_bit;
    logic        grp;
    logic [15:0] vsel;
    logic [31:0] idx_val;
    logic [15:0] idx_lo;
    logic [31:0] stride;
    logic [31:0] eff;
    logic [31:0] last;
    logic [31:0] lim;
    logic        nib_bad;
    logic        any_err;
    logic [31:0] fw_mask;
    logic [31:0] fw_dat;
    logic [31:0] fr_val;

    assign acc_req = req_valid && q.rdy;
    assign is_bit  = (req_type == DOR_T_X) || (req_type == DOR_T_Y)
                   || (req_type == DOR_T_M);
    assign grp     = is_bit && (req_nib != 4'h0);
    assign vsel    = q.v[req_idx_sel];
    // Either index kind modifies any operand except V and Z, which flag an error; nibble count untouched
    assign idx_val = !req_idx_en ? 32'h0 :
                     req_idx_long ? q.z[req_idx_sel] :
                     {{16{vsel[15]}}, vsel};
    assign idx_lo  = idx_val[15:0];
    // Series words: four bits per nibble, one or two registers
    assign stride  = grp ? {26'h0, req_nib, 2'b00} :
                     (req_type != DOR_T_D) ? 32'h0 :
                     req_dbl_marker ? 32'h2 : 32'h1;
    assign eff     = {16'h0, req_num} + idx_val
                   + 32'(stride * {24'h0, req_elem});
    assign last    = eff + (grp ? {26'h0, req_nib, 2'b00} - 32'h1 :
                     {31'h0, req_type == DOR_T_D && req_dbl_marker});
    assign nib_bad = grp && (req_nib >
                     (req_dbl_marker ? DOR_NIB_MAX32 : DOR_NIB_MAX16));

    // Range per device type; file registers share the plain range
    always_comb begin
        unique case (req_type)
            DOR_T_X: lim = DOR_X_LAST;
            DOR_T_Y: lim = DOR_Y_LAST;
            DOR_T_M: lim = DOR_M_LAST;
            DOR_T_D: lim = DOR_D_LAST;
            DOR_T_P: lim = DOR_P_LAST;
            default: lim = DOR_IDX_LAST;
        endcase
    end

    // Operand error detection
    always_comb begin
        any_err = nib_bad;
        if (req_type == DOR_T_V || req_type == DOR_T_Z) begin
            any_err = any_err || req_idx_en
                    || ({16'h0, req_num} > DOR_IDX_LAST);
        end else if (last > lim || eff > lim) begin
            any_err = 1'b1;
        end
        if ((req_cmd == DOR_C_CONTACT || req_cmd == DOR_C_COIL)
            && (!is_bit || grp)) begin
            any_err = 1'b1;
        end
        if ((req_cmd == DOR_C_WRITE || req_cmd == DOR_C_COIL)
            && (req_type == DOR_T_X || req_type == DOR_T_P)) begin
            any_err = 1'b1;
        end
    end

    // Write-side masking of grouped destinations
    dor_group_fmt u_fmt_wr (
        .raw   (32'h0),
        .nib   (req_nib),
        .dbl   (req_dbl_marker),
        .wval  (req_wdata),
        .rval  (),
        .wmask (fw_mask),
        .wdat  (fw_dat)
    );

    // Read-side masking of grouped sources
    dor_group_fmt u_fmt_rd (
        .raw   (bit_rdata),
        .nib   (q.nib),
        .dbl   (q.dbl),
        .wval  (32'h0),
        .rval  (fr_val),
        .wmask (),
        .wdat  ()
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        n     = q;
        n.ack = 1'b0;
        n.bwe = 1'b0;
        n.wwe = 1'b0;
        unique case (q.st)
            S_IDLE: begin
                if (acc_req) begin
                    n.cmd   = req_cmd;
                    n.cop   = req_cop;
                    n.dbl   = req_dbl_marker;
                    n.grp   = grp;
                    n.nib   = req_nib;
                    n.err   = 1'b0;
                    n.wpath = 1'b0;
                    n.addr  = eff[15:0];
                    n.whi   = req_wdata[31:16];
                    n.space = (req_type == DOR_T_X) ? DOR_SP_X :
                              (req_type == DOR_T_Y) ? DOR_SP_Y : DOR_SP_M;
                    if (req_cmd == DOR_C_MOTION) begin
                        n.ack  = 1'b1;
                        n.exec = 1'b1;
                        n.acc  = 1'b1;
                    end else if (req_cmd == DOR_C_FUNC) begin
                        n.ack  = 1'b1;
                        n.exec = q.acc;
                    end else if (any_err) begin
                        n.ack = 1'b1;
                        n.err = 1'b1;
                    end else if (req_type == DOR_T_V) begin
                        n.ack  = 1'b1;
                        n.rdat = {16'h0, q.v[req_num[2:0]]};
                        if (req_cmd == DOR_C_WRITE) begin
                            n.v[req_num[2:0]] = req_wdata[15:0];
                        end
                    end else if (req_type == DOR_T_Z) begin
                        n.ack  = 1'b1;
                        n.rdat = q.z[req_num[2:0]];
                        if (req_cmd == DOR_C_WRITE) begin
                            n.z[req_num[2:0]] = req_dbl_marker ? req_wdata
                                : {{16{req_wdata[15]}}, req_wdata[15:0]};
                        end
                    end else if (req_type == DOR_T_P) begin
                        n.ack  = 1'b1;
                        n.rdat = eff;
                    end else if (req_cmd == DOR_C_COIL && !q.acc) begin
                        n.ack = 1'b1;
                    end else begin
                        n.st  = S_LO;
                        n.rdy = 1'b0;
                        if (req_type == DOR_T_D) begin
                            n.wwe  = (req_cmd == DOR_C_WRITE);
                            n.wdat = req_wdata[15:0];
                            n.wpath = 1'b1;
                        end else if (req_cmd == DOR_C_COIL) begin
                            n.bwe   = 1'b1;
                            n.bmask = 32'h0000_0001;
                            n.bdat  = {31'h0, req_coil_set};
                        end else if (req_cmd == DOR_C_WRITE) begin
                            n.bwe   = 1'b1;
                            n.bmask = grp ? fw_mask : 32'h0000_0001;
                            n.bdat  = grp ? fw_dat :
                                      {31'h0, req_wdata[0]};
                        end
                    end
                end
            end
            S_LO: begin
                if (q.cmd == DOR_C_CONTACT) begin
                    // Contact sampled once, right now
                    unique case (q.cop)
                        DOR_O_LD:  n.acc = bit_rdata[0];
                        DOR_O_LDI: n.acc = !bit_rdata[0];
                        DOR_O_AND: n.acc = q.acc && bit_rdata[0];
                        DOR_O_ANI: n.acc = q.acc && !bit_rdata[0];
                        DOR_O_OR:  n.acc = q.acc || bit_rdata[0];
                        default:   n.acc = q.acc || !bit_rdata[0];
                    endcase
                end
                n.rdat = q.grp ? fr_val : {31'h0, bit_rdata[0]};
                // A word write holds the last read value here, then the word path below loads word_rdata
                if (q.wwe) begin
                    n.rdat = q.rdat;
                end
                n.st  = S_IDLE;
                n.ack = 1'b1;
                n.rdy = 1'b1;
                if (q.wpath) begin
                    // Low half from the named register
                    n.rdat = {16'h0, word_rdata};
                    if (q.dbl) begin
                        n.st   = S_HI;
                        n.ack  = 1'b0;
                        n.rdy  = 1'b0;
                        n.addr = q.addr + 16'h1;
                        n.wwe  = q.wwe;
                        n.wdat = q.whi;
                    end
                end
            end
            S_HI: begin
                // High half from the following register
                n.rdat = {word_rdata, q.rdat[15:0]};
                n.st   = S_IDLE;
                n.ack  = 1'b1;
                n.rdy  = 1'b1;
            end
            default: begin
                n.st  = S_IDLE;
                n.rdy = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            q     <= '0;
            q.st  <= S_IDLE;
            q.rdy <= 1'b1;
            q.acc <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign req_ready   = q.rdy;
    assign ack         = q.ack;
    assign op_err      = q.err;
    assign rd_data     = q.rdat;
    assign contact_acc = q.acc;
    assign exec_en     = q.exec;
    assign bit_space   = q.space;
    assign bit_addr    = q.addr;
    assign bit_we      = q.bwe;
    assign bit_wmask   = q.bmask;
    assign bit_wdata   = q.bdat;
    assign word_addr   = q.addr;
    assign word_we     = q.wwe;
    assign word_wdata  = q.wdat;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_s_n);

    property p_nib;
        acc_req && nib_bad && req_cmd != DOR_C_MOTION
            && req_cmd != DOR_C_FUNC |=> ack && op_err;
    endproperty
    a_nib: assert property (p_nib) else $error("bad nibble");

    property p_dblidx;
        acc_req && req_type == DOR_T_V && req_idx_en
            && req_cmd == DOR_C_READ |=> ack && op_err;
    endproperty
    a_dblidx: assert property (p_dblidx)
        else $error("indexed index accepted");

    property p_range;
        acc_req && req_type == DOR_T_M && !req_idx_en
            && req_cmd == DOR_C_READ && {16'h0, req_num} > DOR_M_LAST
            |=> op_err && !bit_we;
    endproperty
    a_range: assert property (p_range)
        else $error("range not flagged");

    property p_zero;
        ack && !op_err && q.grp && q.cmd == DOR_C_READ
            && q.nib < DOR_NIB_MAX32 |-> (rd_data >> {q.nib, 2'b00}) == 0;
    endproperty
    a_zero: assert property (p_zero)
        else $error("bits above group set");

    property p_wmask;
        bit_we && q.grp && q.nib < DOR_NIB_MAX32
            |-> (bit_wmask >> {q.nib, 2'b00}) == 0;
    endproperty
    a_wmask: assert property (p_wmask)
        else $error("write past group");

    property p_pair;
        q.st == S_HI && word_we |-> word_addr == $past(word_addr) + 16'h1;
    endproperty
    a_pair: assert property (p_pair)
        else $error("high half not next register");

    property p_coil;
        acc_req && req_cmd == DOR_C_COIL && !contact_acc
            |=> !bit_we [*2];
    endproperty
    a_coil: assert property (p_coil)
        else $error("coil driven while off");

    property p_motion;
        acc_req && req_cmd == DOR_C_MOTION |=> ack && exec_en;
    endproperty
    a_motion: assert property (p_motion)
        else $error("motion blocked");

    property p_index;
        acc_req && req_type == DOR_T_D && req_idx_en && !req_idx_long
            && req_elem == 8'h0 && !any_err && req_cmd == DOR_C_READ
            |=> word_addr == $past(req_num) + $past(idx_lo);
    endproperty
    a_index: assert property (p_index)
        else $error("index not added");

    property p_dbl;
        acc_req && req_type == DOR_T_D && req_dbl_marker && !any_err
            && req_cmd == DOR_C_READ
            |=> q.st == S_LO ##1 q.st == S_HI ##1 ack;
    endproperty
    a_dbl: assert property (p_dbl)
        else $error("32-bit access not paired");

    c_motion: cover property (acc_req && req_cmd == DOR_C_MOTION);
    c_dbl:    cover property (q.st == S_HI && word_we);
    c_grp:    cover property (bit_we && q.grp);
    c_err:    cover property (ack && op_err);

endmodule : dor_resolver

// >>> design/dor_pkg.sv
package dor_pkg;

    // ************************************************************
    // Operand kinds, commands and contact operations
    // ************************************************************
    typedef enum logic [2:0] {
        DOR_T_X = 3'h0,
        DOR_T_Y = 3'h1,
        DOR_T_M = 3'h2,
        DOR_T_D = 3'h3,
        DOR_T_V = 3'h4,
        DOR_T_Z = 3'h5,
        DOR_T_P = 3'h6
    } dor_type_e;

    typedef enum logic [2:0] {
        DOR_C_READ    = 3'h0,
        DOR_C_WRITE   = 3'h1,
        DOR_C_CONTACT = 3'h2,
        DOR_C_COIL    = 3'h3,
        DOR_C_MOTION  = 3'h4,
        DOR_C_FUNC    = 3'h5
    } dor_cmd_e;

    typedef enum logic [2:0] {
        DOR_O_LD  = 3'h0,
        DOR_O_LDI = 3'h1,
        DOR_O_AND = 3'h2,
        DOR_O_ANI = 3'h3,
        DOR_O_OR  = 3'h4,
        DOR_O_ORI = 3'h5
    } dor_cop_e;

    // ************************************************************
    // Bit storage spaces, device ranges, group limits
    // ************************************************************
    localparam logic [1:0]  DOR_SP_X      = 2'h0;
    localparam logic [1:0]  DOR_SP_Y      = 2'h1;
    localparam logic [1:0]  DOR_SP_M      = 2'h2;
    localparam logic [31:0] DOR_X_LAST    = 32'h0000_00ff;
    localparam logic [31:0] DOR_Y_LAST    = 32'h0000_0037;
    localparam logic [31:0] DOR_M_LAST    = 32'h0000_01ff;
    localparam logic [31:0] DOR_D_LAST    = 32'h0000_1b57;
    localparam logic [31:0] DOR_P_LAST    = 32'h0000_00ff;
    localparam logic [31:0] DOR_IDX_LAST  = 32'h0000_0007;
    localparam logic [3:0]  DOR_NIB_MAX16 = 4'h4;
    localparam logic [3:0]  DOR_NIB_MAX32 = 4'h8;

endpackage : dor_pkg

// >>> design/dor_group_fmt.sv
`timescale 1ns/1ps

// Nibble-group masking for grouped bit operands
module dor_group_fmt (
    input  wire logic [31:0] raw,
    input  wire logic [3:0]  nib,
    input  wire logic        dbl,
    input  wire logic [31:0] wval,
    output logic      [31:0] rval,
    output logic      [31:0] wmask,
    output logic      [31:0] wdat
);
    import dor_pkg::*;

    logic [31:0] gmask;
    logic [31:0] imask;

    // ************************************************************
    // Group width and instruction width masks
    // ************************************************************
    always_comb begin
        if (nib >= DOR_NIB_MAX32) begin
            gmask = 32'hffff_ffff;
        end else begin
            gmask = (32'h0000_0001 << {nib, 2'b00}) - 32'h0000_0001;
        end
        imask = dbl ? 32'hffff_ffff : 32'h0000_ffff;
    end

    // Zero above the group; eight nibbles keep the sign bit
    assign rval  = raw & gmask & imask;
    // Overflowing high bits are never stored
    assign wmask = gmask & imask;
    assign wdat  = wval & gmask & imask;

endmodule : dor_group_fmt

// >>> tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import dor_pkg::*;
    // ****************************************
    // Stimulus and storage model
    // ****************************************
    logic        clk, rst_n, req_valid, dbl, cset, ie, il;
    dor_cmd_e    cmd;
    dor_type_e   typ;
    dor_cop_e    cop;
    logic [15:0] num, bit_addr, word_addr, word_wdata;
    logic [3:0]  nib;
    logic [7:0]  elem;
    logic [2:0]  isel;
    logic [31:0] wd, rd_data, bit_wmask, bit_wdata, rv, wm, wdv;
    logic [1:0]  bit_space;
    logic        req_ready, ack, op_err, contact_acc, exec_en;
    logic        bit_we, word_we, ev, bw;
    logic [15:0] wa0, wd0, wa1, wd1;
    logic [17:0] ba;
    int          nw, nb;
    int          n_errors = 0;
    int          tests_run = 0;

    // Storage patterns differ per address
    function automatic logic [31:0] bf(input logic [15:0] a);
        return {a ^ 16'h9e37, a ^ 16'h1234};
    endfunction : bf
    function automatic logic [15:0] wf(input logic [15:0] a);
        return a ^ 16'h3c5a;
    endfunction : wf
    wire logic [31:0] bit_rdata  = bf(bit_addr);
    wire logic [15:0] word_rdata = wf(word_addr);

    dor_resolver uut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_cmd(cmd), .req_type(typ), .req_cop(cop),
        .req_dbl_marker(dbl), .req_coil_set(cset), .req_num(num),
        .req_nib(nib), .req_elem(elem), .req_idx_en(ie),
        .req_idx_long(il), .req_idx_sel(isel), .req_wdata(wd),
        .req_ready(req_ready), .ack(ack), .op_err(op_err),
        .rd_data(rd_data), .contact_acc(contact_acc), .exec_en(exec_en),
        .bit_space(bit_space), .bit_addr(bit_addr), .bit_we(bit_we),
        .bit_wmask(bit_wmask), .bit_wdata(bit_wdata),
        .bit_rdata(bit_rdata), .word_addr(word_addr), .word_we(word_we),
        .word_wdata(word_wdata), .word_rdata(word_rdata));

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // One request, answer captured with any bit write
    task automatic op(input dor_cmd_e c, input dor_type_e t,
                      input logic [15:0] n, input logic [3:0] k,
                      input logic [31:0] w);
        cmd = c;
        typ = t;
        num = n;
        nib = k;
        wd = w;
        bw = 1'b0;
        nw = 0;
        nb = 0;
        req_valid = 1'b1;
        @(posedge clk);
        #1 req_valid = 1'b0;
        // Strobes stand one cycle: record them before the next edge
        for (int i = 0; i < 6 && ack !== 1'b1; i++) begin
            if (bit_we === 1'b1) begin
                bw = 1'b1;
                wm = bit_wmask;
                wdv = bit_wdata;
                ba = {bit_space, bit_addr};
            end
            if (word_we === 1'b1) begin
                if (nw == 0) {wa0, wd0} = {word_addr, word_wdata};
                else {wa1, wd1} = {word_addr, word_wdata};
                nw++;
            end
            if (req_ready === 1'b0) nb++;
            @(posedge clk);
            #1;
        end
        rv = rd_data;
        ev = op_err;
        chk("ack", 1, ack);
    endtask : op

    task automatic t_word;
        dbl = 1'b1;
        op(DOR_C_READ, DOR_T_D, 16'h000a, 4'h0, 0);
        chk("d32", {wf(16'h000b), wf(16'h000a)}, rv);
        op(DOR_C_WRITE, DOR_T_D, 16'h0014, 4'h0, 32'h1234_5678);
        chk("d32 lo", {16'h0014, 16'h5678}, {wa0, wd0});
        chk("d32 hi", {16'h0015, 16'h1234}, {wa1, wd1});
        chk("busy", 2, nb);
        op(DOR_C_WRITE, DOR_T_Z, 16'h0003, 4'h0, 32'h8765_4321);
        op(DOR_C_READ, DOR_T_Z, 16'h0003, 4'h0, 0);
        chk("z3", 32'h8765_4321, rv);
        op(DOR_C_WRITE, DOR_T_Z, 16'h0002, 4'h0, 32'h3);
        dbl = 1'b0;
        op(DOR_C_WRITE, DOR_T_V, 16'h0001, 4'h0, 32'h5);
        op(DOR_C_READ, DOR_T_V, 16'h0001, 4'h0, 0);
        chk("v1", 32'h5, rv);
        ie = 1'b1;
        isel = 3'h1;
        op(DOR_C_READ, DOR_T_D, 16'h000a, 4'h0, 0);
        chk("indexed", {16'h0, wf(16'h000f)}, rv);
        il = 1'b1;
        isel = 3'h2;
        op(DOR_C_READ, DOR_T_D, 16'h000a, 4'h0, 0);
        chk("zindexed", {16'h0, wf(16'h000d)}, rv);
        il = 1'b0;
        ie = 1'b0;
    endtask : t_word

    task automatic t_group;
        op(DOR_C_READ, DOR_T_M, 16'h0010, 4'h2, 0);
        chk("k2", bf(16'h0010) & 32'hff, rv);
        dbl = 1'b1;
        op(DOR_C_READ, DOR_T_M, 16'h0010, 4'h8, 0);
        chk("k8", bf(16'h0010), rv);
        dbl = 1'b0;
        op(DOR_C_WRITE, DOR_T_Y, 16'h0008, 4'h1, 32'hbeef);
        chk("wmask", 32'hf, wm);
        chk("wdata", 32'hbeef & 32'hf, wdv);
        chk("waddr", {DOR_SP_Y, 16'h0008}, ba);
        elem = 8'h2;
        op(DOR_C_READ, DOR_T_M, 16'h0000, 4'h3, 0);
        chk("series", bf(16'h0018) & 32'hfff, rv);
        elem = 8'h0;
    endtask : t_group

    task automatic t_err;
        op(DOR_C_WRITE, DOR_T_M, 16'h0000, 4'h5, 0);
        chk("nib", 2, {ev, bw});
        ie = 1'b1;
        op(DOR_C_READ, DOR_T_V, 16'h0001, 4'h0, 0);
        chk("vidx", 1, ev);
        ie = 1'b0;
        op(DOR_C_READ, DOR_T_D, 16'h1b58, 4'h0, 0);
        chk("range", 1, ev);
        op(DOR_C_READ, DOR_T_M, 16'h0200, 4'h0, 0);
        chk("mrange", 1, ev);
    endtask : t_err

    task automatic t_seq;
        op(DOR_C_CONTACT, DOR_T_X, 16'h0000, 4'h0, 0);
        chk("acc", 0, contact_acc);
        op(DOR_C_COIL, DOR_T_Y, 16'h0000, 4'h0, 0);
        chk("coil", 0, bw);
        op(DOR_C_FUNC, DOR_T_X, 16'h0000, 4'h0, 0);
        chk("func", 0, exec_en);
        op(DOR_C_MOTION, DOR_T_X, 16'h0000, 4'h0, 0);
        chk("exec", 1, exec_en);
        cset = 1'b1;
        op(DOR_C_COIL, DOR_T_Y, 16'h0003, 4'h0, 0);
        chk("coil set", 32'h3, {bw, wdv[0]});
        cset = 1'b0;
        cop = DOR_O_ANI;
        op(DOR_C_CONTACT, DOR_T_X, 16'h0001, 4'h0, 0);
        chk("ani", 0, contact_acc);
        cop = DOR_O_ORI;
        op(DOR_C_CONTACT, DOR_T_X, 16'h0000, 4'h0, 0);
        chk("ori", 1, contact_acc);
    endtask : t_seq

    task automatic summarize;
        if (n_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        {rst_n, req_valid, dbl, cset, ie, il, num, nib, elem, isel} = '0;
        cmd = DOR_C_READ;
        typ = DOR_T_X;
        cop = DOR_O_LD;
        wd = '0;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        t_word();
        t_group();
        t_err();
        t_seq();
        summarize();
    end

    initial begin
        #300us;
        n_errors++;
        summarize();
    end
endmodule : tb_top
